// ---- hw/spfc_block_counter.v ----
// one queue's block usage counter: grants allocation below the limit
// assumes alloc and release requests are on clk and single-cycle
`include "spfc_regs.vh"

module spfc_block_counter #(
  parameter W = 5
) (
  input wire clk, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire [W-1:0] limit, // programmed block limit
  input wire allocReq, // request for one more block
  input wire releaseReq, // one block returned
  output wire allocGrant, // request granted this cycle
  output reg [W-1:0] count_reg // blocks in use
);
  assign allocGrant = allocReq && (count_reg < limit);

  always @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= {W{1'b0}};
    end else if (allocGrant && !(releaseReq && count_reg != {W{1'b0}})) begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end else if (!allocGrant && releaseReq && count_reg != {W{1'b0}}) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // spfc_block_counter

// ---- hw/spfc_port_fifo_config.v ----
// apb register bank for port fifo limits, usage, flow thresholds,
// default vlan tag, priority map, mac gap level and source address.
// assumes an apb master on clk; fifo and packet events on clk.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`include "spfc_regs.vh"

module spfc_port_fifo_config (
  input wire clk, // system clock, 200 mhz
  input wire sys_rst, // synchronous reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always one
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error on unmapped address
  input wire p0TxAllocReq, // port 0 tx wants a block
  input wire p0TxRelease, // port 0 tx frees a block
  input wire p0RxAllocReq, // port 0 rx wants a block
  input wire p0RxRelease, // port 0 rx frees a block
  input wire p2TxAllocReq, // port 2 tx wants a block
  input wire p2TxRelease, // port 2 tx frees a block
  input wire p2RxAllocReq, // port 2 rx wants a block
  input wire p2RxRelease, // port 2 rx frees a block
  output wire p0TxAllocGrant, // port 0 tx block granted
  output wire p0RxAllocGrant, // port 0 rx block granted
  output wire p2TxAllocGrant, // port 2 tx block granted
  output wire p2RxAllocGrant, // port 2 rx block granted
  input wire [4:0] port1TxBlocksInUse, // port 1 tx usage
  output reg port0RxFlowControl, // port 0 receive flow control
  input wire [2:0] headerPriority, // priority of packet being queued
  output reg [1:0] switchQueuePriority, // mapped queue priority
  input wire tagValid, // a received tag to process
  input wire [15:0] tagIn, // received tag control field
  output reg [15:0] tagOut, // tag after default vid handling
  output reg tagOutValid, // tagOut valid pulse
  output reg [4:0] port0ShortGapLevel, // mac short gap level
  output reg [47:0] macSourceAddress // byte 0 of saLo_reg in bits 15-8
);
  reg [8:0] p0Limits_reg;
  reg [8:0] p2Limits_reg;
  reg [12:0] p0Thresh_reg;
  reg [15:0] p0Vlan_reg;
  reg [31:0] p0PriMap_reg;
  reg [4:0] gap_reg;
  reg [15:0] saLo_reg;
  reg [31:0] saHi_reg;
  reg [2:0] ctrl_reg;
  wire [4:0] p0TxUse;
  wire [3:0] p0RxUse;
  wire [4:0] p2TxUse;
  wire [3:0] p2RxUse;
  wire wrEn;
  wire rdEn;
  reg mapped;
  reg [31:0] rdNext;

  // zero-extend a packed tx/rx usage or limit pair into a bus word
  function [31:0] pairWord;
    input [4:0] tx;
    input [3:0] rx;
    begin
      pairWord = {23'h000000, tx, rx};
    end
  endfunction

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  spfc_block_counter #(.W(5)) p0TxCnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .limit(p0Limits_reg[`SPFC_TX_MSB:`SPFC_TX_LSB]),
    .allocReq(p0TxAllocReq),
    .releaseReq(p0TxRelease),
    .allocGrant(p0TxAllocGrant),
    .count_reg(p0TxUse)
  );
  spfc_block_counter #(.W(4)) p0RxCnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .limit(p0Limits_reg[`SPFC_RX_MSB:`SPFC_RX_LSB]),
    .allocReq(p0RxAllocReq),
    .releaseReq(p0RxRelease),
    .allocGrant(p0RxAllocGrant),
    .count_reg(p0RxUse)
  );
  spfc_block_counter #(.W(5)) p2TxCnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .limit(p2Limits_reg[`SPFC_TX_MSB:`SPFC_TX_LSB]),
    .allocReq(p2TxAllocReq),
    .releaseReq(p2TxRelease),
    .allocGrant(p2TxAllocGrant),
    .count_reg(p2TxUse)
  );
  spfc_block_counter #(.W(4)) p2RxCnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .limit(p2Limits_reg[`SPFC_RX_MSB:`SPFC_RX_LSB]),
    .allocReq(p2RxAllocReq),
    .releaseReq(p2RxRelease),
    .allocGrant(p2RxAllocGrant),
    .count_reg(p2RxUse)
  );

  // register writes take effect at the access-phase edge
  always @(posedge clk) begin
    if (sys_rst) begin
      p0Limits_reg <= `SPFC_RST_LIMITS;
      p2Limits_reg <= `SPFC_RST_LIMITS;
      p0Thresh_reg <= `SPFC_RST_THRESH;
      p0Vlan_reg <= `SPFC_RST_VLAN;
      p0PriMap_reg <= `SPFC_RST_PRIMAP;
      gap_reg <= `SPFC_RST_GAP;
      saLo_reg <= `SPFC_RST_SA_LO;
      saHi_reg <= `SPFC_RST_SA_HI;
      ctrl_reg <= `SPFC_RST_CTRL;
    end else if (wrEn) begin
      if (paddr == `SPFC_OFS_P0_LIMITS) begin
        p0Limits_reg <= pwdata[8:0];
      end else if (paddr == `SPFC_OFS_P0_THRESH) begin
        p0Thresh_reg <= pwdata[12:0];
      end else if (paddr == `SPFC_OFS_P0_VLAN) begin
        p0Vlan_reg <= pwdata[15:0];
      end else if (paddr == `SPFC_OFS_P0_PRIMAP) begin
        p0PriMap_reg <= pwdata & `SPFC_PRIMAP_MASK;
      end else if (paddr == `SPFC_OFS_GAP) begin
        gap_reg <= pwdata[`SPFC_GAP_MSB:0];
      end else if (paddr == `SPFC_OFS_SA_LO) begin
        saLo_reg <= pwdata[15:0];
      end else if (paddr == `SPFC_OFS_SA_HI) begin
        saHi_reg <= pwdata;
      end else if (paddr == `SPFC_OFS_P2_LIMITS) begin
        p2Limits_reg <= pwdata[8:0];
      end else if (paddr == `SPFC_OFS_CTRL) begin
        ctrl_reg <= pwdata[2:0];
      end
    end
  end

  // read mux; unused bits stay zero
  always @* begin
    mapped = 1'b1;
    rdNext = 32'h00000000;
    if (paddr == `SPFC_OFS_P0_LIMITS) begin
      rdNext = pairWord(p0Limits_reg[8:4], p0Limits_reg[3:0]);
    end else if (paddr == `SPFC_OFS_P0_USAGE) begin
      rdNext = pairWord(p0TxUse, p0RxUse);
    end else if (paddr == `SPFC_OFS_P0_THRESH) begin
      rdNext = {19'h00000, p0Thresh_reg[12:8], 3'h0,
                p0Thresh_reg[4:0]};
    end else if (paddr == `SPFC_OFS_P0_VLAN) begin
      rdNext = {16'h0000, p0Vlan_reg};
    end else if (paddr == `SPFC_OFS_P0_PRIMAP) begin
      rdNext = p0PriMap_reg;
    end else if (paddr == `SPFC_OFS_GAP) begin
      rdNext = {27'h0000000, gap_reg};
    end else if (paddr == `SPFC_OFS_SA_LO) begin
      rdNext = {16'h0000, saLo_reg};
    end else if (paddr == `SPFC_OFS_SA_HI) begin
      rdNext = saHi_reg;
    end else if (paddr == `SPFC_OFS_P2_LIMITS) begin
      rdNext = pairWord(p2Limits_reg[8:4], p2Limits_reg[3:0]);
    end else if (paddr == `SPFC_OFS_P2_USAGE) begin
      rdNext = pairWord(p2TxUse, p2RxUse);
    end else if (paddr == `SPFC_OFS_CTRL) begin
      rdNext = {29'h00000000, ctrl_reg};
    end else begin
      mapped = 1'b0;
    end
  end

  // read data is captured in the setup cycle, valid in the access phase
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (rdEn) begin
      prdata <= rdNext;
    end
  end

  // flow control, priority mapping, tag handling and mac outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      port0RxFlowControl <= 1'b0;
      switchQueuePriority <= 2'h0;
      tagOut <= 16'h0000;
      tagOutValid <= 1'b0;
      port0ShortGapLevel <= 5'h00;
      macSourceAddress <= `SPFC_RST_SA;
    end else begin
      port0RxFlowControl <=
        (ctrl_reg[`SPFC_CTRL_EN_P2_BIT] &&
         p2TxUse >= p0Thresh_reg[`SPFC_TH_P2_MSB:`SPFC_TH_P2_LSB]) ||
        (ctrl_reg[`SPFC_CTRL_EN_P1_BIT] &&
         port1TxBlocksInUse >=
           p0Thresh_reg[`SPFC_TH_P1_MSB:`SPFC_TH_P1_LSB]);
      switchQueuePriority <=
        p0PriMap_reg[{headerPriority, 2'b00} +: 2];
      tagOutValid <= tagValid;
      if (tagValid) begin
        if (!ctrl_reg[`SPFC_CTRL_PASS_BIT] &&
            tagIn[`SPFC_VID_MSB:`SPFC_VID_LSB] == 12'h000) begin
          tagOut <= {tagIn[15:12],
                     p0Vlan_reg[`SPFC_VID_MSB:`SPFC_VID_LSB]};
        end else begin
          tagOut <= tagIn;
        end
      end
      port0ShortGapLevel <= gap_reg;
      macSourceAddress <= {saHi_reg[7:0], saHi_reg[15:8], saHi_reg[23:16],
                           saHi_reg[31:24], saLo_reg[7:0],
                           saLo_reg[15:8]};
    end
  end
endmodule // spfc_port_fifo_config

// ---- hw/spfc_regs.vh ----
// register offsets, field positions and reset values of the port fifo
// configuration bank; included by the design files by bare name
`ifndef SPFC_REGS_VH
`define SPFC_REGS_VH
`define SPFC_OFS_P0_LIMITS 12'h000
`define SPFC_OFS_P0_USAGE 12'h004
`define SPFC_OFS_P0_THRESH 12'h008
`define SPFC_OFS_P0_VLAN 12'h00C
`define SPFC_OFS_P0_PRIMAP 12'h010
`define SPFC_OFS_GAP 12'h014
`define SPFC_OFS_SA_LO 12'h018
`define SPFC_OFS_SA_HI 12'h01C
`define SPFC_OFS_P2_LIMITS 12'h020
`define SPFC_OFS_P2_USAGE 12'h024
`define SPFC_OFS_CTRL 12'h028
`define SPFC_TX_MSB 8
`define SPFC_TX_LSB 4
`define SPFC_RX_MSB 3
`define SPFC_RX_LSB 0
`define SPFC_TH_P2_MSB 12
`define SPFC_TH_P2_LSB 8
`define SPFC_TH_P1_MSB 4
`define SPFC_TH_P1_LSB 0
`define SPFC_PRI_MSB 15
`define SPFC_PRI_LSB 13
`define SPFC_CFI_BIT 12
`define SPFC_VID_MSB 11
`define SPFC_VID_LSB 0
`define SPFC_GAP_MSB 4
`define SPFC_CTRL_PASS_BIT 2
`define SPFC_CTRL_EN_P2_BIT 1
`define SPFC_CTRL_EN_P1_BIT 0
`define SPFC_RST_LIMITS 9'h000
`define SPFC_RST_THRESH 13'h0000
`define SPFC_RST_VLAN 16'h0000
`define SPFC_RST_PRIMAP 32'h33333333
`define SPFC_PRIMAP_MASK 32'h33333333
`define SPFC_RST_GAP 5'h00
`define SPFC_RST_SA 48'h000000000000
`define SPFC_RST_SA_LO 16'h0000
`define SPFC_RST_SA_HI 32'h00000000
`define SPFC_RST_CTRL 3'h0
`endif

// ---- tb/spfc_checker.sv ----
// assertions on the port fifo configuration bank's ports
// bound to the bank from the bench top file; one clock, sync reset
module spfc_checker (
  input wire clk, // clock
  input wire sys_rst, // reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire [31:0] prdata, // apb read data
  input wire p0TxAllocReq, // tx request
  input wire p0TxAllocGrant, // tx grant
  input wire [4:0] port0ShortGapLevel, // gap level
  input wire [47:0] macSourceAddress // source address
);
  timeunit 1ns;
  timeprecision 100ps;
  wire rdAcc = psel && penable && !pwrite;
  wire wrAcc = psel && penable && pwrite;
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_grant_needs_req: assert property (p0TxAllocGrant |-> p0TxAllocReq)
    else $error("tx grant without request");
  a_limit_resv_zero: assert property (rdAcc && (paddr == 12'h000 ||
    paddr == 12'h020) |-> prdata[31:9] == 23'h0)
    else $error("limit reserved bits set");
  a_usage_resv_zero: assert property (rdAcc && (paddr == 12'h004 ||
    paddr == 12'h024) |-> prdata[31:9] == 23'h0)
    else $error("usage reserved bits set");
  a_thresh_resv_zero: assert property (rdAcc && paddr == 12'h008 |->
    prdata[31:13] == 19'h0 && prdata[7:5] == 3'h0)
    else $error("threshold reserved bits set");
  a_salo_resv_zero: assert property (rdAcc && paddr == 12'h018 |->
    prdata[31:16] == 16'h0)
    else $error("address low reserved bits set");
  a_map_resv_zero: assert property (rdAcc && paddr == 12'h010 |->
    (prdata & 32'hCCCCCCCC) == 32'h0)
    else $error("map reserved bits set");
  a_gap_resv_zero: assert property (rdAcc && paddr == 12'h014 |->
    prdata[31:5] == 27'h0)
    else $error("gap reserved bits set");
  a_gap_follows: assert property (wrAcc && paddr == 12'h014 |->
    ##2 port0ShortGapLevel == $past(pwdata[4:0], 2))
    else $error("gap level not taken");
  a_sa_low_bytes: assert property (wrAcc && paddr == 12'h018 |->
    ##2 macSourceAddress[15:0] == {$past(pwdata[7:0], 2),
    $past(pwdata[15:8], 2)})
    else $error("address bytes misplaced");
endmodule // spfc_checker

// ---- tb/test_spfc_port_fifo_config.sv ----
// bench for the port fifo configuration bank
// drives apb and fifo events itself; checker bound at the foot
`define CHK(n, e, g) begin \
  automatic logic [47:0] ev = (e); \
  n_checks++; \
  if ((g) !== ev) begin \
    err_count++; \
    $display("Error %s expected %h seen %h", n, ev, g); \
  end \
end
module test_spfc_port_fifo_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic tagValid = 0, pready, pslverr, flow, tagOutValid;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r = 32'h1EB805F5, wv[10], rdQ[$];
  logic [31:0] msk[10] = '{32'h1FF, 32'h0, 32'h1F1F, 32'hFFFF,
    32'h33333333, 32'h1F, 32'hFFFF, 32'hFFFFFFFF, 32'h1FF, 32'h0};
  logic [3:0] req = 0, rel = 0, grant;
  logic [4:0] p1Use = 0, gap, lim[4], cnt[4];
  logic [2:0] hp = 0;
  logic [1:0] qp;
  logic [15:0] tagIn = 0, tagOut, tagQ[$];
  logic [47:0] sa, saExp;
  int err_count = 0, n_checks = 0, cyc = 0;
  spfc_port_fifo_config i_spfc_port_fifo_config (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .p0TxAllocReq(req[0]), .p0TxRelease(rel[0]),
    .p0RxAllocReq(req[1]), .p0RxRelease(rel[1]), .p2TxAllocReq(req[2]),
    .p2TxRelease(rel[2]), .p2RxAllocReq(req[3]), .p2RxRelease(rel[3]),
    .p0TxAllocGrant(grant[0]), .p0RxAllocGrant(grant[1]),
    .p2TxAllocGrant(grant[2]), .p2RxAllocGrant(grant[3]),
    .port1TxBlocksInUse(p1Use), .port0RxFlowControl(flow),
    .headerPriority(hp), .switchQueuePriority(qp), .tagValid(tagValid),
    .tagIn(tagIn), .tagOut(tagOut), .tagOutValid(tagOutValid),
    .port0ShortGapLevel(gap), .macSourceAddress(sa));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  initial forever #2.5 clk = ~clk;
  // read results and tags are taken in order off the notes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
    if (psel && penable)
      `CHK("pslverr", paddr > 12'h028, pslverr)
    if (psel && penable && !pwrite && rdQ.size() > 0)
      `CHK("prdata", rdQ.pop_front(), prdata)
    if (tagOutValid === 1'b1)
      `CHK("tagOut", tagQ.pop_front(), tagOut)
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++)
      rd(12'(i * 4), i == 4 ? 32'h33333333 : 32'h0);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      r = lfsr(r);
      wv[i] = r;
      apb(1'b1, 12'(i * 4), r);
    end
    for (int i = 0; i < 10; i++)
      rd(12'(i * 4), wv[i] & msk[i]);
    `CHK("gap", wv[5][4:0], gap)
    saExp = {wv[7][7:0], wv[7][15:8], wv[7][23:16], wv[7][31:24],
      wv[6][7:0], wv[6][15:8]};
    `CHK("sa", saExp, sa)
    for (int n = 0; n < 8; n++) begin
      hp <= 3'(n);
      repeat (2) @(posedge clk);
      `CHK("queue", wv[4][4 * n +: 2], qp)
    end
    $display("register access done");
    apb(1'b1, 12'h000, 32'h113);
    apb(1'b1, 12'h020, 32'h104);
    lim = '{5'h11, 5'h3, 5'h10, 5'h4};
    cnt = '{default: 5'h0};
    req <= 4'hF;
    for (int k = 0; k < 20; k++) begin
      #1;
      for (int q = 0; q < 4; q++) begin
        `CHK("grant", cnt[q] < lim[q], grant[q])
        cnt[q] += 5'(cnt[q] < lim[q]);
      end
      @(posedge clk);
    end
    req <= 4'h0;
    rel <= 4'hF;
    @(posedge clk);
    rel <= 4'h0;
    for (int q = 0; q < 4; q++)
      cnt[q] -= 5'h1;
    rd(12'h004, {cnt[0], cnt[1][3:0]});
    rd(12'h024, {cnt[2], cnt[3][3:0]});
    apb(1'b1, 12'h000, 32'h0E6);
    req <= 4'h3;
    #1;
    `CHK("grant", 2'b10, grant[1:0])
    @(posedge clk);
    req <= 4'h0;
    $display("block counters done");
    apb(1'b1, 12'h008, {19'h0, cnt[2], 8'h05});
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 12'h028, 32'(c));
      for (int u = 3; u < 7; u++) begin
        p1Use <= 5'(u);
        repeat (2) @(posedge clk);
        `CHK("flow", (c == 1 && u >= 5) || c == 2, flow)
      end
    end
    $display("flow control done");
    r = lfsr(r);
    apb(1'b1, 12'h00C, r);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 12'h028, 32'(c * 4));
      for (int v = 0; v < 2; v++) begin
        tagIn <= {4'hB, v ? 12'h123 : 12'h000};
        tagQ.push_back({4'hB, v ? 12'h123 : c ? 12'h000 : r[11:0]});
        tagValid <= 1'b1;
        @(posedge clk);
        tagValid <= 1'b0;
        @(posedge clk);
      end
    end
    repeat (4) @(posedge clk);
    $display("tag handling done");
    stop_test();
  end
endmodule // test_spfc_port_fifo_config
bind spfc_port_fifo_config spfc_checker i_spfc_checker (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .p0TxAllocReq(p0TxAllocReq), .p0TxAllocGrant(p0TxAllocGrant),
  .port0ShortGapLevel(port0ShortGapLevel),
  .macSourceAddress(macSourceAddress));
